// ---- rtl/spei_defines.svh ----
// Purpose: Register indices, field positions and reset values for the
//          sink port and edge interrupt block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef SPEI_DEFINES_SVH
`define SPEI_DEFINES_SVH

// Register indices
`define SPEI_IDX_P2_IRQ_EN 8'h06
`define SPEI_IDX_P3_IRQ_EN 8'h07
`define SPEI_IDX_SINK_DATA 8'h30
`define SPEI_IDX_SINK_IRQ_EN 8'h31
`define SPEI_IDX_SINK_IRQ_POL 8'h32
`define SPEI_IDX_STRENGTH0 8'h38
`define SPEI_IDX_STRENGTH7 8'h3f
`define SPEI_IDX_GPIO_CTRL 8'h40
`define SPEI_IDX_PROC_CTRL 8'h41
`define SPEI_IDX_P2_IRQ_POL 8'h42
`define SPEI_IDX_P3_IRQ_POL 8'h43

// Field positions
`define SPEI_BIT_GPIO_GLOBAL_EN 0
`define SPEI_BIT_IRQ_SENSE 2
`define SPEI_BIT_SUSPEND 3

// Masks and reset values
`define SPEI_P3_EN_MASK 8'h7f
`define SPEI_SINK_PIN_MASK 8'h87
`define SPEI_SINK_DATA_RST 8'hff
`define SPEI_ZERO_RST 8'h00
`define SPEI_CODE_RST 4'h0

// Linear strength scale: current = Imax*(BASE+STEP*code)/75
`define SPEI_SINK_BASE 7'h0f
`define SPEI_SINK_STEP 7'h04

`endif

// ---- rtl/spei_pkg.sv ----
// Purpose: Shared types of the sink port and edge interrupt block.
// Assumes: Constants live in spei_defines.svh.
// Notes:   Types only.
package spei_pkg;
  // One register byte
  typedef logic [7:0] spei_byte_t;
  // One sink strength code
  typedef logic [3:0] spei_code_t;
  // Scaled sink current, units of max/75
  typedef logic [6:0] spei_cur_t;
endpackage

// ---- rtl/spei_edge_detect.sv ----
// Purpose: Synchronise a group of pins and flag polarity-matched edges.
// Assumes: Pins are asynchronous to pclk.
// Notes:   A level change counts once the second and third stage agree.
`timescale 1ns/1ns
module spei_edge_detect #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and polarity, one selects rising
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] polarity,
  // Filtered level and one-cycle edge events
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] edge_event
);

  logic [WIDTH-1:0] sync1; // First stage, read only by sync2
  logic [WIDTH-1:0] sync2; // Second stage
  logic [WIDTH-1:0] sync3; // Third stage
  logic [WIDTH-1:0] prev; // Level one cycle ago

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Accepted level follows only where stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '1;
      prev <= '1;
    end else begin
      level <= (level & ~(sync2 ~^ sync3)) | (sync3 & (sync2 ~^ sync3)); // R20
      prev <= level;
    end
  end

  // Rising edge where polarity is one, falling where it is zero
  always_comb begin
    edge_event = (polarity & level & ~prev) |
                 (~polarity & ~level & prev); // R1 R16 R20
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_edge_single_cycle: assert property ( // R20
    @(posedge pclk) disable iff (!presetn)
    (edge_event != '0) |=> ((edge_event & $past(edge_event)) == '0))
    else $error("edge event lasted more than one cycle");

  a_edge_polarity_match: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    ((edge_event & polarity & ~(level & ~$past(level))) == '0) &&
    ((edge_event & ~polarity & ~(~level & $past(level))) == '0))
    else $error("edge event against selected polarity");

endmodule

// ---- rtl/spei_sink_port.sv ----
// Overview of operation
// R1: Positive polarity rising, negative polarity falling edges
// R2: Port interrupt needs pin, global, sense, edge
// R3: Port 2 pin enables, write-only, reset zero
// R4: Port 3 enables bits 6..0, bit 7 reserved
// R5: Data one: sink off, pull-up on
// R6: Data zero: programmed sink on, pull-up off
// R7: Each sink pin has sixteen strength levels
// R8: Suspend disables every sink current
// R9: Software sets data to all ones before suspend
// R10: Strength registers 0x38..0x3f in pin order
// R11: Code maps linearly from one fifth to max
// R12: Strength registers write-only, four bits, reset zero
// R13: Sink port per-pin interrupt enable, write-only
// R14: Reset clears sink interrupt enables
// R15: Sink pin events share one interrupt request
// R16: Sink polarity register, one rising, zero falling
// R17: Sink data bits 7,2,1,0, reset to ones
// R18: Interrupt sense reads live, writes ignored
// R19: Suspend write halts; enabled interrupt or bus wakes
// R20: Pins synchronised, edges flagged for one cycle
// R21: Sink data read returns synchronised pin levels
//
// Purpose: APB register file, edge interrupts and current-sink pin control.
// Assumes: APB slave with zero wait states; index = paddr[9:2].
// Notes:   Analog sink and pull-up sit outside; this drives their controls.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "spei_defines.svh"
module spei_sink_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor side status
  input wire logic irq_sense,
  input wire logic bus_activity,
  output logic suspend,
  // General port pins
  input wire logic [7:0] port2_pin_in,
  input wire logic [7:0] port3_pin_in,
  output logic gpio_irq,
  // Current-sink port pins
  input wire logic [7:0] sink_pin_in,
  output logic [7:0] sink_on,
  output logic [7:0] pullup_on,
  output logic [55:0] sink_current,
  output logic sink_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  spei_pkg::spei_byte_t port2_pin_irq_en_bit; // Port 2 pin enables
  spei_pkg::spei_byte_t port3_pin_irq_en_bit; // Port 3 pin enables
  spei_pkg::spei_byte_t sink_port_output_data; // Sink data latch
  spei_pkg::spei_byte_t sink_port_irq_enable; // Sink pin enables
  spei_pkg::spei_byte_t sink_port_irq_polarity; // Sink edge select
  spei_pkg::spei_byte_t port2_irq_polarity; // Port 2 edge select
  spei_pkg::spei_byte_t port3_irq_polarity; // Port 3 edge select
  logic gpio_global_en; // Global port interrupt enable
  spei_pkg::spei_code_t strength [8]; // Per-pin strength code

  // Decode
  logic [7:0] idx; // Register index
  logic wr_en; // Write in access phase
  logic setup; // Setup phase
  logic mapped; // Index is a known register
  logic [31:0] next_prdata; // Read value
  logic next_suspend; // Suspend for next cycle
  logic next_gpio_irq; // Port interrupt request
  logic next_sink_irq; // Sink interrupt request
  logic [7:0] next_sink_on; // Sink control
  logic [55:0] next_sink_current; // Scaled currents

  // Edge detector outputs
  logic [7:0] p2_level;
  logic [7:0] p2_event;
  logic [7:0] p3_level;
  logic [7:0] p3_event;
  logic [7:0] sk_level;
  logic [7:0] sk_event;

  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  ////////////////////////////////////////////////////////////////////////
  // Edge detectors for the three pin groups
  spei_edge_detect #(.WIDTH(8)) u_edge_p2 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(port2_pin_in),
    .polarity(port2_irq_polarity),
    .level(p2_level),
    .edge_event(p2_event)
  );

  spei_edge_detect #(.WIDTH(8)) u_edge_p3 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(port3_pin_in),
    .polarity(port3_irq_polarity),
    .level(p3_level),
    .edge_event(p3_event)
  );

  spei_edge_detect #(.WIDTH(8)) u_edge_sk (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sink_pin_in),
    .polarity(sink_port_irq_polarity),
    .level(sk_level),
    .edge_event(sk_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address map check
  always_comb begin
    mapped = (paddr[1:0] == 2'h0) &&
      ((idx == `SPEI_IDX_P2_IRQ_EN) || (idx == `SPEI_IDX_P3_IRQ_EN) ||
       ((idx >= `SPEI_IDX_SINK_DATA) && (idx <= `SPEI_IDX_SINK_IRQ_POL)) ||
       ((idx >= `SPEI_IDX_STRENGTH0) && (idx <= `SPEI_IDX_P3_IRQ_POL)));
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      // Live pin levels, not the latch
      `SPEI_IDX_SINK_DATA: next_prdata[7:0] = sk_level; // R21
      `SPEI_IDX_GPIO_CTRL:
        next_prdata[`SPEI_BIT_GPIO_GLOBAL_EN] = gpio_global_en;
      `SPEI_IDX_PROC_CTRL: begin
        next_prdata[`SPEI_BIT_IRQ_SENSE] = irq_sense; // R18
        next_prdata[`SPEI_BIT_SUSPEND] = suspend;
      end
      `SPEI_IDX_P2_IRQ_POL: next_prdata[7:0] = port2_irq_polarity;
      `SPEI_IDX_P3_IRQ_POL: next_prdata[7:0] = port3_irq_polarity;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Bus answer, captured in setup so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General port enables and polarities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_pin_irq_en_bit <= `SPEI_ZERO_RST; // R3
      port3_pin_irq_en_bit <= `SPEI_ZERO_RST; // R4
      port2_irq_polarity <= `SPEI_ZERO_RST;
      port3_irq_polarity <= `SPEI_ZERO_RST;
      gpio_global_en <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        `SPEI_IDX_P2_IRQ_EN: port2_pin_irq_en_bit <= pwdata[7:0]; // R3
        // Reserved bit 7 is held at zero
        `SPEI_IDX_P3_IRQ_EN:
          port3_pin_irq_en_bit <= pwdata[7:0] & `SPEI_P3_EN_MASK; // R4
        `SPEI_IDX_P2_IRQ_POL: port2_irq_polarity <= pwdata[7:0];
        `SPEI_IDX_P3_IRQ_POL: port3_irq_polarity <= pwdata[7:0];
        `SPEI_IDX_GPIO_CTRL:
          gpio_global_en <= pwdata[`SPEI_BIT_GPIO_GLOBAL_EN];
        default: gpio_global_en <= gpio_global_en;
      endcase
    end
  end

  // Sink port data, enables and polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_port_output_data <= `SPEI_SINK_DATA_RST; // R17
      sink_port_irq_enable <= `SPEI_ZERO_RST; // R14
      sink_port_irq_polarity <= `SPEI_ZERO_RST; // R16
    end else if (wr_en) begin
      case (idx)
        // Unbonded bits stay at one
        `SPEI_IDX_SINK_DATA: sink_port_output_data <=
          pwdata[7:0] | ~`SPEI_SINK_PIN_MASK; // R17
        `SPEI_IDX_SINK_IRQ_EN: sink_port_irq_enable <= pwdata[7:0]; // R13
        `SPEI_IDX_SINK_IRQ_POL:
          sink_port_irq_polarity <= pwdata[7:0]; // R16
        default: sink_port_irq_enable <= sink_port_irq_enable;
      endcase
    end
  end

  // Strength codes, one register per pin in pin order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        strength[i] <= `SPEI_CODE_RST; // R12
      end
    end else if (wr_en && (idx >= `SPEI_IDX_STRENGTH0) &&
                 (idx <= `SPEI_IDX_STRENGTH7)) begin
      strength[idx[2:0]] <= pwdata[3:0]; // R7 R10 R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt qualification
  always_comb begin
    next_gpio_irq = gpio_global_en & irq_sense &
      (|((p2_event & port2_pin_irq_en_bit) |
         (p3_event & port3_pin_irq_en_bit))); // R2
    next_sink_irq = |(sk_event & sink_port_irq_enable &
                      `SPEI_SINK_PIN_MASK); // R15
  end

  // Registered one-cycle requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_irq <= 1'b0;
      sink_irq <= 1'b0;
    end else begin
      gpio_irq <= next_gpio_irq; // R2
      sink_irq <= next_sink_irq; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Suspend: write with no bus activity enters; wake takes priority
  always_comb begin
    next_suspend = suspend;
    if (wr_en && idx == `SPEI_IDX_PROC_CTRL &&
        pwdata[`SPEI_BIT_SUSPEND] && !bus_activity) begin
      next_suspend = 1'b1; // R19
    end
    if (next_gpio_irq || next_sink_irq || bus_activity) begin
      next_suspend = 1'b0; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend <= 1'b0;
    end else begin
      suspend <= next_suspend; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: zero sinks, one pulls up; suspend cuts every sink
  always_comb begin
    next_sink_on = ~sink_port_output_data & `SPEI_SINK_PIN_MASK &
                   {8{~next_suspend}}; // R6 R8
    for (int i = 0; i < 8; i++) begin
      next_sink_current[i*7 +: 7] = `SPEI_SINK_BASE +
        7'(`SPEI_SINK_STEP * {3'h0, strength[i]}); // R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_on <= 8'h00;
      pullup_on <= `SPEI_SINK_DATA_RST;
      sink_current <= {8{`SPEI_SINK_BASE}};
    end else begin
      sink_on <= next_sink_on; // R6 R8
      pullup_on <= sink_port_output_data; // R5
      sink_current <= next_sink_current; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_p2_write;
    wr_en && idx == `SPEI_IDX_P2_IRQ_EN;
  endsequence

  a_p2_enable_store: assert property ( // R3
    s_p2_write |=> port2_pin_irq_en_bit == $past(pwdata[7:0]))
    else $error("port 2 enable not stored");

  a_p3_reserved_zero: assert property ( // R4
    port3_pin_irq_en_bit[7] == 1'b0)
    else $error("port 3 reserved enable bit set");

  a_gpio_irq_cause: assert property ( // R2
    gpio_irq |-> $past(gpio_global_en) && $past(irq_sense))
    else $error("port interrupt without global enable or sense");

  a_sink_irq_enable: assert property ( // R13
    sink_irq |-> $past(|(sk_event & sink_port_irq_enable)))
    else $error("sink interrupt without enabled event");

  a_suspend_no_sink: assert property ( // R8
    suspend |-> sink_on == 8'h00)
    else $error("sink active during suspend");

  a_pullup_sink_excl: assert property ( // R5
    (sink_on & pullup_on) == 8'h00)
    else $error("sink and pull-up on together");

  a_zero_turns_sink: assert property ( // R6
    ##1 (!next_suspend && !sink_port_output_data[0]) |=> sink_on[0])
    else $error("zero data did not turn sink on");

  a_strength_map: assert property ( // R11
    wr_en && idx == `SPEI_IDX_STRENGTH7 |=> ##1
      sink_current[55:49] == 7'(7'h0f + 7'h04 * {3'h0, $past(pwdata[3:0], 2)}))
    else $error("pin 7 strength not scaled");

  a_sink_read_pins: assert property ( // R21
    setup && !pwrite && idx == `SPEI_IDX_SINK_DATA && paddr[1:0] == 2'h0
      |=> prdata[7:0] == $past(sk_level))
    else $error("sink data read not pin level");

  a_wake_on_bus: assert property ( // R19
    suspend && bus_activity |=> !suspend)
    else $error("bus activity did not wake");

endmodule

// ---- tb/spei_pin_model.sv ----
// Purpose: Board side of the sink pins: loads, drivers and floating.
// Assumes: Board drivers overpower the on-chip sink and pull-up.
// Notes:   An undriven pin shows a level that flips every cycle.
`timescale 1ns/1ns
module spei_pin_model (
  // Clock for the floating pattern
  input wire logic pclk,
  // Controls from the port
  input wire logic [7:0] sink_on,
  input wire logic [7:0] pullup_on,
  // Board drivers, enable and level
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_lvl,
  // Resolved pin levels
  output logic [7:0] pin
);
  logic flt = 1'b0; // Pattern of an undriven pin

  ////////////////////////////////////////////////////////////////////////
  // Floating pattern toggles so no stale level survives
  always @(posedge pclk) begin
    flt <= ~flt;
  end

  // Resolve each pin from all parties
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i]) begin
        pin[i] = ext_lvl[i]; // Board overdrives
      end else if (sink_on[i]) begin
        pin[i] = 1'b0; // Sink pulls low
      end else if (pullup_on[i]) begin
        pin[i] = 1'b1; // Pull-up pulls high
      end else begin
        pin[i] = flt; // Floats if left low in suspend
      end
    end
  end
endmodule

// ---- tb/sink_port_edge_interrupts_tb.sv ----
// Purpose: Self-checking bench for the sink port and edge interrupts.
// Assumes: Zero-wait APB slave; pin model on the sink pins.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/1ns
module sink_port_edge_interrupts_tb;
  // Clock, reset and APB
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Processor status and pins
  logic irq_sense = 1'b0;
  logic bus_activity = 1'b0;
  logic suspend;
  logic [7:0] p2 = 8'hff;
  logic [7:0] p3 = 8'hff;
  logic gpio_irq;
  logic [7:0] sink_pin;
  logic [7:0] sink_on;
  logic [7:0] pullup_on;
  logic [55:0] sink_current;
  logic sink_irq;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_lvl = 8'hff;
  // Bookkeeping
  int n_fail = 0;
  int num_checks = 0;
  int g_cnt = 0;
  int s_cnt = 0;
  logic [31:0] rd;
  logic err;

  spei_sink_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_sense(irq_sense), .bus_activity(bus_activity),
    .suspend(suspend), .port2_pin_in(p2), .port3_pin_in(p3),
    .gpio_irq(gpio_irq), .sink_pin_in(sink_pin), .sink_on(sink_on),
    .pullup_on(pullup_on), .sink_current(sink_current),
    .sink_irq(sink_irq));

  spei_pin_model board (.pclk(pclk), .sink_on(sink_on),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .pin(sink_pin));

  ////////////////////////////////////////////////////////////////////////
  // Clock and interrupt pulse counters
  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    if (gpio_irq === 1'b1) begin
      g_cnt <= g_cnt + 1;
    end
    if (sink_irq === 1'b1) begin
      s_cnt <= s_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Access phase lasts until pready is seen high; watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h000000, d});
  endtask

  // Move pins, then count interrupt pulses over ten cycles
  task automatic step(input logic [7:0] a2, input logic [7:0] a3,
                      input logic [7:0] lvl, input int eg, input int es);
    int g0;
    int s0;
    g0 = g_cnt;
    s0 = s_cnt;
    p2 <= a2;
    p3 <= a3;
    ext_lvl <= lvl;
    cyc(10);
    chk(g_cnt - g0, eg);
    chk(s_cnt - s0, es);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk(pullup_on, 8'hff);
    chk(sink_on, 8'h00);
    chk(sink_current, {8{7'h0f}});
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, 8'h06, 32'h0);
    chk({err, rd}, 33'h0);
    apb(1'b0, 8'h37, 32'h0);
    chk(err, 1'b1);
  endtask

  task automatic t_data;
    wr(8'h30, 8'h00);
    cyc(6);
    chk(sink_on, 8'h87);
    chk(pullup_on, 8'h78);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0000_0078);
    wr(8'h30, 8'h85);
    cyc(2);
    chk(sink_on, 8'h02);
    chk(pullup_on, 8'hfd);
    ext_en <= 8'h01;
    ext_lvl <= 8'h00;
    cyc(6);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0000_00fc);
    ext_en <= 8'h00;
  endtask

  task automatic t_strength;
    logic [3:0] c;
    for (int i = 0; i < 8; i++) begin
      c = (i == 7) ? 4'hf : 4'(2 * i);
      apb(1'b1, 8'h38 + 8'(i), {28'hfffffff, c});
    end
    cyc(2);
    for (int i = 0; i < 8; i++) begin
      c = (i == 7) ? 4'hf : 4'(2 * i);
      chk(sink_current[7*i +: 7], 7'h0f + 7'h04 * 7'(c));
    end
  endtask

  task automatic t_suspend;
    wr(8'h41, 8'h08);
    cyc(2);
    chk(suspend, 1'b1);
    chk(sink_on, 8'h00);
    bus_activity <= 1'b1;
    cyc(3);
    chk(suspend, 1'b0);
    wr(8'h41, 8'h08);
    cyc(2);
    chk(suspend, 1'b0);
    bus_activity <= 1'b0;
    irq_sense <= 1'b1;
    wr(8'h41, 8'h00);
    apb(1'b0, 8'h41, 32'h0);
    chk(rd, 32'h0000_0004);
    irq_sense <= 1'b0;
    wr(8'h41, 8'h04);
    apb(1'b0, 8'h41, 32'h0);
    chk(rd, 32'h0000_0000);
    wr(8'h30, 8'hff);
  endtask

  task automatic t_gpio;
    wr(8'h40, 8'h01);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h40);
    wr(8'h42, 8'h00);
    wr(8'h43, 8'h40);
    apb(1'b0, 8'h43, 32'h0);
    chk(rd, 32'h0000_0040);
    irq_sense <= 1'b1;
    step(8'hfe, 8'hff, 8'hff, 1, 0);
    step(8'hff, 8'hff, 8'hff, 0, 0);
    step(8'hff, 8'hbf, 8'hff, 0, 0);
    step(8'hff, 8'hff, 8'hff, 1, 0);
    // Sink data already all ones, so suspend leaves no pin floating
    wr(8'h41, 8'h08);
    cyc(1);
    chk(suspend, 1'b1);
    step(8'hfe, 8'hff, 8'hff, 1, 0);
    chk(suspend, 1'b0);
    step(8'hfd, 8'hff, 8'hff, 0, 0);
    irq_sense <= 1'b0;
    step(8'hfc, 8'hff, 8'hff, 0, 0);
    irq_sense <= 1'b1;
    step(8'hff, 8'hff, 8'hff, 0, 0);
    wr(8'h40, 8'h00);
    step(8'hfe, 8'hff, 8'hff, 0, 0);
  endtask

  task automatic t_sink;
    wr(8'h31, 8'h80);
    wr(8'h32, 8'h80);
    ext_en <= 8'h84;
    cyc(8);
    step(8'hfe, 8'hff, 8'h7f, 0, 0);
    step(8'hfe, 8'hff, 8'hff, 0, 1);
    wr(8'h32, 8'h00);
    step(8'hfe, 8'hff, 8'h7f, 0, 1);
    step(8'hfe, 8'hff, 8'h7b, 0, 0);
    wr(8'h31, 8'h84);
    step(8'hfe, 8'hff, 8'hff, 0, 0);
    step(8'hfe, 8'hff, 8'h7b, 0, 1);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    chk(pullup_on, 8'hff);
    step(8'hfe, 8'hff, 8'hff, 0, 0);
    step(8'hfe, 8'hff, 8'h7b, 0, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    t_reset;
    t_data;
    t_strength;
    t_suspend;
    t_gpio;
    t_sink;
    close_out;
  end

  initial begin
    #500000;
    n_fail++;
    close_out;
  end
endmodule
